// ---- ntor_map.vh ----
// Register offsets, reset values and field positions of the neighbour test and trim registers
`ifndef NTOR_MAP_VH
`define NTOR_MAP_VH
// ==========================================
// Register offsets (page one, trim entries on page two)
`define NTOR_PAGE_ADDR        8'h00
`define NTOR_TOP_TEST_LO_ADDR 8'h51
`define NTOR_TOP_TEST_HI_ADDR 8'h52
`define NTOR_TOP_CAP_LO_ADDR  8'h53
`define NTOR_TOP_CAP_HI_ADDR  8'h54
`define NTOR_BOT_TEST_LO_ADDR 8'h55
`define NTOR_BOT_TEST_HI_ADDR 8'h56
`define NTOR_BOT_CAP_LO_ADDR  8'h57
`define NTOR_BOT_CAP_HI_ADDR  8'h58
`define NTOR_TRIM_FIRST_ADDR  8'h01
`define NTOR_DUMMY_TRIM_ADDR  8'hff
// ==========================================
// Reset values
`define NTOR_TEST_RST         8'h00
`define NTOR_TRIM_RST         8'h80
// ==========================================
// Field positions
`define NTOR_TOP_MODE_HI      1
`define NTOR_TOP_MODE_LO      0
`define NTOR_BOT_MODE_HI      7
`define NTOR_BOT_MODE_LO      6
`define NTOR_BOT_TEST_HI_MSB  5
`define NTOR_PAGE_BIT         0
// ==========================================
// Serial slave and trim store constants
`define NTOR_DEV_ADDR_HI      2'h2
`define NTOR_BYTE_BITS        4'h8
`define NTOR_TRIM_ENTRIES     255
`define NTOR_TRIM_BITS        8
`endif

// ---- ntor_sync.v ----
// Two-flop synchroniser for a bus of asynchronous pad levels
`timescale 1ns/1ns
module ntor_sync #(
  parameter W = 1
) (
  input  wire         sys_clk,
  input  wire         rst_n,
  input  wire [W-1:0] async_in,
  output reg  [W-1:0] sync_out
);

  reg [W-1:0] meta_q;

  // ==========================================
  // Synchroniser stages
  // First stage feeds only the second stage
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q   <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// ---- ntor_trim_mem.v ----
// Offset trim code store: one byte per channel plus the dummy channel
`timescale 1ns/1ns
`include "ntor_map.vh"
module ntor_trim_mem (
  input  wire                                        sys_clk,
  input  wire                                        rst_n,
  input  wire                                        wr_en,
  input  wire [7:0]                                  wr_addr,
  input  wire [7:0]                                  wr_data,
  input  wire [7:0]                                  rd_addr,
  output reg  [7:0]                                  rd_data,
  output wire [`NTOR_TRIM_ENTRIES*`NTOR_TRIM_BITS-1:0] trim_codes
);

  reg [7:0] trim_q [1:`NTOR_TRIM_ENTRIES];

  // ==========================================
  // Trim entries
  genvar i;
  generate
    for (i = 1; i <= `NTOR_TRIM_ENTRIES; i = i + 1) begin : g_entry
      localparam integer ENTRY_NUM = i;
      always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          trim_q[i] <= `NTOR_TRIM_RST;
        end else if (wr_en && (wr_addr == ENTRY_NUM[7:0])) begin
          trim_q[i] <= wr_data;
        end
      end
      assign trim_codes[(i-1)*`NTOR_TRIM_BITS +: `NTOR_TRIM_BITS] = trim_q[i];
    end
  endgenerate

  // ==========================================
  // Read port, address zero has no entry
  always @* begin
    if (rd_addr == 8'h00) begin
      rd_data = 8'h00;
    end else begin
      rd_data = trim_q[rd_addr];
    end
  end

endmodule

// ---- ntor_top.v ----
// Neighbour hit test registers, output capture and offset trim behind a two-wire slave
`timescale 1ns/1ns
`include "ntor_map.vh"
module ntor_top (
  input  wire          sys_clk,
  input  wire          rst_n,
  input  wire          scl_in,
  input  wire          sda_in,
  output wire          sda_out,
  output wire          sda_oe,
  input  wire [4:0]    dev_addr_pin,
  input  wire [2:0]    top_seed_layer_in,
  input  wire [12:0]   top_corr_layer_in,
  input  wire [1:0]    bottom_seed_layer_in,
  input  wire [11:0]   bottom_corr_layer_in,
  input  wire [1:0]    top_seed_layer_out,
  input  wire [11:0]   top_corr_layer_out,
  input  wire [2:0]    bottom_seed_layer_out,
  input  wire [12:0]   bottom_corr_layer_out,
  output reg  [2:0]    sfl_top_seed_in,
  output reg  [12:0]   sfl_top_corr_in,
  output reg  [1:0]    sfl_bot_seed_in,
  output reg  [11:0]   sfl_bot_corr_in,
  output wire [2031:0] chan_offset_trim,
  output wire [7:0]    dummy_offset_trim
);

  // Slave states
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_ADDR  = 3'h1;
  localparam [2:0] ST_AACK  = 3'h2;
  localparam [2:0] ST_REG   = 3'h3;
  localparam [2:0] ST_WDATA = 3'h4;
  localparam [2:0] ST_WACK  = 3'h5;
  localparam [2:0] ST_RDATA = 3'h6;
  localparam [2:0] ST_RACK  = 3'h7;

  wire [36:0] sync_w;
  wire        scl_s;
  wire        sda_s;
  wire [4:0]  dev_addr_s;
  wire [2:0]  top_seed_s;
  wire [12:0] top_corr_s;
  wire [1:0]  bot_seed_s;
  wire [11:0] bot_corr_s;

  reg         scl_q;
  reg         sda_q;
  reg  [2:0]  st_q;
  reg  [3:0]  bit_q;
  reg  [7:0]  shift_q;
  reg         rw_q;
  reg  [7:0]  ptr_q;
  reg         drv_q;
  reg         page_q;
  reg  [7:0]  top_test_lo_q;
  reg  [7:0]  top_test_hi_q;
  reg  [1:0]  top_mode_q;
  reg  [7:0]  bot_test_lo_q;
  reg  [7:0]  bot_test_hi_q;
  reg         wr_en;
  reg  [7:0]  rd_data;

  wire        scl_rise;
  wire        scl_fall;
  wire        start_det;
  wire        stop_det;
  wire        byte_done;
  wire        top_test_en;
  wire        bot_test_en;
  wire        trim_wr;
  wire [7:0]  trim_rd;
  wire [2039:0] trim_all;

  // ==========================================
  // Pad synchronisation
  ntor_sync #(
    .W (37)
  ) u_sync (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .async_in ({dev_addr_pin, top_seed_layer_in, top_corr_layer_in,
                bottom_seed_layer_in, bottom_corr_layer_in, ~scl_in, ~sda_in}),
    .sync_out (sync_w)
  );

  assign dev_addr_s = sync_w[36:32];
  assign top_seed_s = sync_w[31:29];
  assign top_corr_s = sync_w[28:16];
  assign bot_seed_s = sync_w[15:14];
  assign bot_corr_s = sync_w[13:2];
  assign scl_s      = ~sync_w[1]; // Pins enter inverted so reset reads idle high
  assign sda_s      = ~sync_w[0];

  // Delayed copies for edge and condition detection
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  assign scl_rise  = scl_s & ~scl_q;
  assign scl_fall  = ~scl_s & scl_q;
  assign start_det = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_det  = scl_s & scl_q & ~sda_q & sda_s;
  assign byte_done = (bit_q == `NTOR_BYTE_BITS);

  // Open-drain data line, only ever pulled low
  assign sda_out = 1'b0;
  assign sda_oe  = drv_q;

  // ==========================================
  // Register read multiplexer
  always @* begin
    rd_data = 8'h00;
    if (page_q && (ptr_q != `NTOR_PAGE_ADDR)) begin // Page register seen on both pages
      rd_data = trim_rd;
    end else begin
      case (ptr_q)
        `NTOR_PAGE_ADDR:        rd_data = {7'h00, page_q};
        `NTOR_TOP_TEST_LO_ADDR: rd_data = top_test_lo_q;
        `NTOR_TOP_TEST_HI_ADDR: rd_data = top_test_hi_q;
        `NTOR_TOP_CAP_LO_ADDR:  rd_data = {top_corr_layer_out[3:0], top_seed_layer_out,
                                           top_mode_q};
        `NTOR_TOP_CAP_HI_ADDR:  rd_data = top_corr_layer_out[11:4];
        `NTOR_BOT_TEST_LO_ADDR: rd_data = bot_test_lo_q;
        `NTOR_BOT_TEST_HI_ADDR: rd_data = bot_test_hi_q;
        `NTOR_BOT_CAP_LO_ADDR:  rd_data = {bottom_corr_layer_out[4:0], bottom_seed_layer_out};
        `NTOR_BOT_CAP_HI_ADDR:  rd_data = bottom_corr_layer_out[12:5];
        default:                rd_data = 8'h00;
      endcase
    end
  end

  // ==========================================
  // Two-wire slave state machine
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q    <= ST_IDLE;
      bit_q   <= 4'h0;
      shift_q <= 8'h00;
      rw_q    <= 1'b0;
      ptr_q   <= 8'h00;
      drv_q   <= 1'b0;
      wr_en   <= 1'b0;
    end else begin
      wr_en <= 1'b0;
      if (start_det) begin
        st_q  <= ST_ADDR;
        bit_q <= 4'h0;
        drv_q <= 1'b0;
      end else if (stop_det) begin
        st_q  <= ST_IDLE;
        drv_q <= 1'b0;
      end else begin
        case (st_q)
          ST_ADDR, ST_REG, ST_WDATA: begin
            if (scl_rise && !byte_done) begin
              shift_q <= {shift_q[6:0], sda_s};
              bit_q   <= bit_q + 4'h1;
            end else if (scl_fall && byte_done) begin
              bit_q <= 4'h0;
              if (st_q == ST_ADDR) begin
                if (shift_q[7:1] == {`NTOR_DEV_ADDR_HI, dev_addr_s}) begin
                  rw_q  <= shift_q[0];
                  drv_q <= 1'b1;
                  st_q  <= ST_AACK;
                end else begin
                  st_q <= ST_IDLE;
                end
              end else if (st_q == ST_REG) begin
                ptr_q <= shift_q;
                drv_q <= 1'b1;
                st_q  <= ST_WACK;
              end else begin
                wr_en <= 1'b1;
                drv_q <= 1'b1;
                st_q  <= ST_WACK;
              end
            end
          end
          ST_AACK: begin
            if (scl_fall) begin
              if (rw_q) begin
                shift_q <= rd_data;
                drv_q   <= ~rd_data[7];
                st_q    <= ST_RDATA;
              end else begin
                drv_q <= 1'b0;
                st_q  <= ST_REG;
              end
            end
          end
          ST_WACK: begin
            if (scl_fall) begin
              drv_q <= 1'b0;
              st_q  <= ST_WDATA;
            end
            // Auto-increment after each stored data byte
            if (wr_en) begin
              ptr_q <= ptr_q + 8'h01;
            end
          end
          ST_RDATA: begin
            if (scl_rise) begin
              bit_q <= bit_q + 4'h1;
            end else if (scl_fall) begin
              if (byte_done) begin
                drv_q <= 1'b0;
                ptr_q <= ptr_q + 8'h01;
                st_q  <= ST_RACK;
              end else begin
                shift_q <= {shift_q[6:0], 1'b0};
                drv_q   <= ~shift_q[6];
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              rw_q <= ~sda_s;
            end else if (scl_fall) begin
              bit_q <= 4'h0;
              if (rw_q) begin
                shift_q <= rd_data;
                drv_q   <= ~rd_data[7];
                st_q    <= ST_RDATA;
              end else begin
                st_q <= ST_IDLE;
              end
            end
          end
          default: begin
            st_q  <= ST_IDLE;
            drv_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // ==========================================
  // Page one register writes
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      page_q        <= 1'b0;
      top_test_lo_q <= `NTOR_TEST_RST;
      top_test_hi_q <= `NTOR_TEST_RST;
      top_mode_q    <= 2'h0;
      bot_test_lo_q <= `NTOR_TEST_RST;
      bot_test_hi_q <= `NTOR_TEST_RST;
    end else if (wr_en) begin
      if (ptr_q == `NTOR_PAGE_ADDR) begin
        page_q <= shift_q[`NTOR_PAGE_BIT];
      end else if (!page_q) begin
        case (ptr_q)
          `NTOR_TOP_TEST_LO_ADDR: top_test_lo_q <= shift_q;
          `NTOR_TOP_TEST_HI_ADDR: top_test_hi_q <= shift_q;
          `NTOR_TOP_CAP_LO_ADDR:  top_mode_q    <= shift_q[`NTOR_TOP_MODE_HI:`NTOR_TOP_MODE_LO];
          `NTOR_BOT_TEST_LO_ADDR: bot_test_lo_q <= shift_q;
          `NTOR_BOT_TEST_HI_ADDR: bot_test_hi_q <= shift_q;
          default:                page_q        <= page_q;
        endcase
      end
    end
  end

  // ==========================================
  // Page two trim store
  assign trim_wr = wr_en & page_q;

  ntor_trim_mem u_trim (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .wr_en      (trim_wr),
    .wr_addr    (ptr_q),
    .wr_data    (shift_q),
    .rd_addr    (ptr_q),
    .rd_data    (trim_rd),
    .trim_codes (trim_all)
  );

  assign chan_offset_trim  = trim_all[2031:0];
  assign dummy_offset_trim = trim_all[2039:2032];

  // ==========================================
  // Test input multiplexing toward the stub finder
  // both top bits needed
  assign top_test_en = top_mode_q[1] & top_mode_q[0];
  assign bot_test_en = bot_test_hi_q[`NTOR_BOT_MODE_HI] & bot_test_hi_q[`NTOR_BOT_MODE_LO];

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sfl_top_seed_in <= 3'h0;
      sfl_top_corr_in <= 13'h0000;
      sfl_bot_seed_in <= 2'h0;
      sfl_bot_corr_in <= 12'h000;
    end else begin
      sfl_top_seed_in <= top_test_en ? top_test_lo_q[2:0] : top_seed_s;
      sfl_top_corr_in <= top_test_en ? {top_test_hi_q, top_test_lo_q[7:3]} : top_corr_s;
      sfl_bot_seed_in <= bot_test_en ? bot_test_lo_q[1:0] : bot_seed_s;
      sfl_bot_corr_in <= bot_test_en ?
                         {bot_test_hi_q[`NTOR_BOT_TEST_HI_MSB:0], bot_test_lo_q[7:2]} :
                         bot_corr_s;
    end
  end
endmodule

// ---- ntor_asserts.sv ----
// Port-level assertions for the neighbour test and trim registers
`timescale 1ns/1ns
module ntor_asserts (
  input wire          sys_clk,
  input wire          rst_n,
  input wire          scl_in,
  input wire          sda_out,
  input wire          sda_oe,
  input wire [1:0]    bottom_seed_layer_in,
  input wire [12:0]   top_corr_layer_in,
  input wire [1:0]    sfl_bot_seed_in,
  input wire [12:0]   sfl_top_corr_in,
  input wire [2031:0] chan_offset_trim,
  input wire [7:0]    dummy_offset_trim
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  // ==========
  // Two-wire pin behaviour
  a_sda_pin_low: assert property (
    sda_out == 1'b0) else $error("data pin output not held low");
  a_oe_rise_low: assert property (
    $rose(sda_oe) |-> !scl_in) else $error("data drive began with clock high");
  a_oe_fall_low: assert property (
    $fell(sda_oe) |-> !scl_in) else $error("data drive ended with clock high");
  // ==========
  // Trim store
  a_trim_reset_mid: assert property (
    $rose(rst_n) |-> chan_offset_trim[7:0] == 8'h80 && chan_offset_trim[2031:2024] == 8'h80)
    else $error("channel trim not mid range after reset");
  a_dummy_reset_mid: assert property (
    $rose(rst_n) |-> dummy_offset_trim == 8'h80) else $error("dummy trim not mid range");
  a_trim_write_ack: assert property (
    !$stable(chan_offset_trim) |-> ##[0:8] sda_oe) else $error("channel trim changed idle");
  a_dummy_write_ack: assert property (
    !$stable(dummy_offset_trim) |-> ##[0:8] sda_oe) else $error("dummy trim changed idle");
  // ==========
  // Stub finder inputs move only for pads or writes
  a_bot_seed_cause: assert property (
    !$stable(sfl_bot_seed_in) |-> ($past(bottom_seed_layer_in, 3) !=
    $past(bottom_seed_layer_in, 4) or ##[0:8] sda_oe)) else $error("bottom seed moved");
  a_top_corr_cause: assert property (
    !$stable(sfl_top_corr_in) |-> ($past(top_corr_layer_in, 3) !=
    $past(top_corr_layer_in, 4) or ##[0:8] sda_oe)) else $error("top corr moved");
endmodule

// ---- ntor_i2c_master.sv ----
// Two-wire master model for the slow-control bus
`timescale 1ns/1ns
module ntor_i2c_master (
  input  wire  sys_clk,
  input  wire  sda_oe,
  output logic scl,
  output wire  sda
);
  logic m_low = 1'b0;
  // Open drain with pull-up
  assign sda = !(m_low | sda_oe);
  initial scl = 1'b1;
  // One bus phase, then change after the edge
  task ph();
    repeat (5) @(posedge sys_clk);
    #1;
  endtask
  // Start or repeated start
  task start();
    m_low = 1'b0;
    ph();
    scl = 1'b1;
    ph();
    m_low = 1'b1;
    ph();
    scl = 1'b0;
    ph();
  endtask
  // Stop: data rises with clock high
  task stop();
    m_low = 1'b1;
    ph();
    scl = 1'b1;
    ph();
    m_low = 1'b0;
    ph();
  endtask
  // One bit, line sampled late in high phase
  task bt(input logic b, output logic r);
    m_low = !b;
    ph();
    scl = 1'b1;
    ph();
    r = sda;
    scl = 1'b0;
    ph();
  endtask
  // Byte MSB first, then acknowledge bit
  task xfer(input logic [7:0] w, input logic l, output logic [7:0] r, output logic ak);
    for (int i = 7; i >= 0; i--) bt(w[i], r[i]);
    bt(l, ak);
  endtask
endmodule

// ---- neighbour_test_and_offset_regs_tb_top.sv ----
// Self-checking bench for the neighbour test and trim registers
`timescale 1ns/1ns
module neighbour_test_and_offset_regs_tb_top;
  // ==========
  // Signals
  logic          sys_clk = 1'b0;
  logic          rst_n = 1'b0;
  logic [4:0]    dev_addr_pin = 5'h00;
  logic [2:0]    top_seed_layer_in = 3'h0;
  logic [12:0]   top_corr_layer_in = 13'h0000;
  logic [1:0]    bottom_seed_layer_in = 2'h0;
  logic [11:0]   bottom_corr_layer_in = 12'h000;
  logic [1:0]    top_seed_layer_out = 2'h0;
  logic [11:0]   top_corr_layer_out = 12'h000;
  logic [2:0]    bottom_seed_layer_out = 3'h0;
  logic [12:0]   bottom_corr_layer_out = 13'h0000;
  wire           scl_in, sda_in, sda_out, sda_oe;
  wire  [2:0]    sfl_top_seed_in;
  wire  [12:0]   sfl_top_corr_in;
  wire  [1:0]    sfl_bot_seed_in;
  wire  [11:0]   sfl_bot_corr_in;
  wire  [2031:0] chan_offset_trim;
  wire  [7:0]    dummy_offset_trim;
  logic [7:0]    pm [81:86];
  logic [7:0]    tm [1:255];
  logic          pg = 1'b0;
  int            bad_count = 0;
  int            num_checks = 0;
  localparam logic [1:0] MD [6] = '{2'h3, 2'h1, 2'h3, 2'h2, 2'h0, 2'h3};
  localparam logic [7:0] CH [3] = '{8'h01, 8'hfe, 8'hff};
  // Clock
  always #4 sys_clk = !sys_clk;
  ntor_top u_dut (.sys_clk, .rst_n, .scl_in, .sda_in, .sda_out, .sda_oe, .dev_addr_pin,
    .top_seed_layer_in, .top_corr_layer_in, .bottom_seed_layer_in, .bottom_corr_layer_in,
    .top_seed_layer_out, .top_corr_layer_out, .bottom_seed_layer_out,
    .bottom_corr_layer_out, .sfl_top_seed_in, .sfl_top_corr_in, .sfl_bot_seed_in,
    .sfl_bot_corr_in, .chan_offset_trim, .dummy_offset_trim);
  ntor_i2c_master u_m (.sys_clk, .sda_oe, .scl(scl_in), .sda(sda_in));
  // ==========
  // Checks and expectations
  task chk(input string n, input logic [15:0] s, input logic [15:0] e);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task finish_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    if (a == 8'h00) return {7'h00, pg};
    if (pg) return tm[a];
    case (a)
      8'h51, 8'h52, 8'h55, 8'h56: return pm[a];
      8'h53: return {top_corr_layer_out[3:0], top_seed_layer_out, pm[a][1:0]};
      8'h54: return top_corr_layer_out[11:4];
      8'h57: return {bottom_corr_layer_out[4:0], bottom_seed_layer_out};
      8'h58: return bottom_corr_layer_out[12:5];
      default: return 8'h00;
    endcase
  endfunction
  task chk_mux();
    logic [15:0] e;
    e = {top_seed_layer_in, top_corr_layer_in};
    if (pm[83][1:0] == 2'h3) e = {pm[81][2:0], pm[82], pm[81][7:3]};
    chk("top mux", {sfl_top_seed_in, sfl_top_corr_in}, e);
    e = {2'h0, bottom_seed_layer_in, bottom_corr_layer_in};
    if (pm[86][7:6] == 2'h3) e = {2'h0, pm[85][1:0], pm[86][5:0], pm[85][7:2]};
    chk("bottom mux", {2'h0, sfl_bot_seed_in, sfl_bot_corr_in}, e);
  endtask
  task chk_trim();
    for (int c = 1; c < 255; c++) begin
      chk("chan trim", {8'h00, chan_offset_trim[c*8-8 +: 8]}, {8'h00, tm[c]});
    end
    chk("dummy trim", {8'h00, dummy_offset_trim}, {8'h00, tm[255]});
  endtask
  // ==========
  // Bus cycles and pad stimulus
  task wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    logic ak;
    u_m.start();
    u_m.xfer({2'h2, dev_addr_pin, 1'b0}, 1'b1, r, ak);
    chk("addr ack", {15'h0000, ak}, 16'h0000);
    u_m.xfer(a, 1'b1, r, ak);
    u_m.xfer(d, 1'b1, r, ak);
    u_m.stop();
    if (pg && a != 8'h00) tm[a] = d;
    else if (a == 8'h53) pm[a] = {6'h00, d[1:0]};
    else if (a inside {8'h51, 8'h52, 8'h55, 8'h56}) pm[a] = d;
    if (a == 8'h00) pg = d[0];
  endtask
  task rdc(input logic [7:0] a);
    logic [7:0] r;
    logic ak;
    u_m.start();
    u_m.xfer({2'h2, dev_addr_pin, 1'b0}, 1'b1, r, ak);
    u_m.xfer(a, 1'b1, r, ak);
    u_m.start();
    u_m.xfer({2'h2, dev_addr_pin, 1'b1}, 1'b1, r, ak);
    u_m.xfer(8'hff, 1'b1, r, ak);
    u_m.stop();
    chk("reg read", {8'h00, r}, {8'h00, exp_rd(a)});
  endtask
  task rnd();
    {top_seed_layer_in, top_corr_layer_in, bottom_seed_layer_in,
      bottom_corr_layer_in} = 30'($urandom);
    {top_seed_layer_out, top_corr_layer_out, bottom_seed_layer_out,
      bottom_corr_layer_out} = 30'($urandom);
    u_m.ph();
  endtask
  // ==========
  // Main sequence
  initial begin
    logic [31:0] rv;
    void'($urandom(32'habfc_3ed4));
    foreach (pm[i]) pm[i] = 8'h00;
    foreach (tm[i]) tm[i] = 8'h80;
    dev_addr_pin = 5'($urandom);
    repeat (2) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    u_m.ph();
    chk_trim();
    chk_mux();
    for (int a = 80; a < 90; a++) rdc(8'(a));
    for (int i = 0; i < 6; i++) begin
      rnd();
      rv = $urandom;
      wr(8'h51, rv[7:0]);
      wr(8'h52, rv[15:8]);
      wr(8'h55, rv[23:16]);
      wr(8'h56, {MD[5 - i], rv[29:24]});
      // mode pair with junk capture bits
      wr(8'h53, {rv[31:26], MD[i]});
      wr(8'h59, rv[7:0]);
      rnd();
      chk_mux();
      for (int a = 80; a < 90; a++) rdc(8'(a));
    end
    wr(8'h00, 8'h01);
    rdc(8'h00);
    for (int k = 0; k < 4; k++) begin
      rv = $urandom;
      wr((k < 3) ? CH[k] : (rv[15:8] | 8'h01), rv[7:0]);
      rdc((k < 3) ? CH[k] : (rv[15:8] | 8'h01));
    end
    chk_trim();
    wr(8'h00, 8'h00);
    rdc(8'h53);
    finish_test();
  end
  // Watchdog against a hung bus
  initial begin
    #(8 * 95000);
    bad_count++;
    finish_test();
  end
endmodule
bind ntor_top ntor_asserts u_chk (.sys_clk, .rst_n, .scl_in, .sda_out, .sda_oe,
  .bottom_seed_layer_in, .top_corr_layer_in, .sfl_bot_seed_in, .sfl_top_corr_in,
  .chan_offset_trim, .dummy_offset_trim);
